// ===== rtl/crc_cfg.svh
/*
 Constants for the CPU reset and control block: register map, field positions, reset values
 and pulse timing.
 Assumes the clock runs at 100 MHz and is included by bare name.
*/
// Overview of operation
// - x86 mode: soft reset pulses for four clocks, starting the clock after a hot, shutdown or keyboard reset.
// - Strap sampled after reset picks x86 set or alternate processor set.
// - Alternate mode: hard reset pulses one millisecond on power-good edge or triggers.
// - Shared pin is IRQ_LINE_13 after reset; coprocessor error only when bit 4 set.
// - Interrupt output follows the internal interrupt controller request.
// - Power-good input is a source of the hard reset output in alternate mode only; soft reset ignores it.
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CRC_ADDR_W 8
`define CRC_OFF_PORT_CTRL 8'h92
`define CRC_OFF_SYS_CTRL 8'h4e
`define CRC_OFF_STATUS 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CRC_BIT_HOT_RESET 0
`define CRC_BIT_KBD_RESET 1
`define CRC_BIT_COPROCESSOR_ERROR_IN_EN 4
`define CRC_ST_ALT_MODE 0
`define CRC_ST_SOFT_RST 1
`define CRC_ST_HARD_RST 2
`define CRC_ST_IRQ_LINE_13 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CRC_RST_PORT_CTRL 8'h00
`define CRC_RST_SYS_CTRL 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CRC_CLK_MHZ 100
`define CRC_SOFT_RST_CLKS 4
`define CRC_STRAP_SETTLE_CLKS 4
`define CRC_HARD_RST_US 1000
`define CRC_HARD_RST_CLKS (`CRC_HARD_RST_US * `CRC_CLK_MHZ)

`endif

// ===== rtl/crc_pkg.sv
/*
 Types for the CPU reset and control block.
 Assumes crc_cfg.svh is compiled alongside.
*/
package crc_pkg;
   typedef enum logic [1:0] {
      CRC_IDLE = 2'b00,
      CRC_SOFT = 2'b01,
      CRC_HARD = 2'b10
   } crc_state_t;

   typedef logic [7:0] crc_byte_t;
endpackage

// ===== rtl/crc_sync_if.sv
/*
 Interface joining the pin synchroniser to the control block.
 Assumes one clock domain for both ends.
*/
`timescale 1ns/1ps
interface crc_sync_if #(parameter int W = 3);
   logic [W-1:0] pins;
   logic [W-1:0] level;
   modport sync (input pins, output level);
   modport user (output pins, input level);
endinterface

// ===== rtl/crc_sync.sv
/*
 Three-stage synchroniser; a change is taken once stages two and three agree.
 Assumes asynchronous pin inputs and a single clock.
*/
`timescale 1ns/1ps
module crc_sync #(
   parameter int W = 3
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Pins
   crc_sync_if.sync sif
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } crc_sync_st_t;

   crc_sync_st_t state_q;
   crc_sync_st_t state_d;

   always_comb
   begin
      state_d = state_q;
      state_d.s1 = sif.pins;
      state_d.s2 = state_q.s1;
      state_d.s3 = state_q.s2;
      for (int i = 0; i < W; i++)
      begin
         if (state_q.s2[i] == state_q.s3[i])
         begin
            state_d.lvl[i] = state_q.s3[i];
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign sif.level = state_q.lvl;
endmodule // crc_sync

// ===== rtl/crc_top.sv
/*
 CPU reset and control outputs: soft reset, hard reset, ignore numeric error, interrupt
 output, IRQ_LINE_13 or coprocessor-error selection, with a small register port.
 Assumes a 100 MHz clock, an asynchronous active-high reset, and pins from outside.
*/
`timescale 1ns/1ps
`include "crc_cfg.svh"
module crc_top #(
   parameter int HARD_RST_CLKS = `CRC_HARD_RST_CLKS
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Register port
   input wire logic [`CRC_ADDR_W-1:0] addr_i,
   input wire crc_pkg::crc_byte_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output crc_pkg::crc_byte_t rdata_o,
   // Pins from outside
   input wire logic power_ok_in_i,
   input wire logic alt_mode_strap_i,
   input wire logic irq_line_13_i,
   // Internal events
   input wire logic cpu_shutdown_i,
   input wire logic pic_int_req_i,
   input wire logic pic_ack_i,
   // Processor outputs
   output logic cpu_int_o,
   output logic soft_reset_o,
   output logic host_hard_reset_out_o,
   output logic ignore_fpu_error_out_o,
   output logic irq_line_13_req_o,
   output logic fpu_error_o
);
   import crc_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   crc_sync_if #(.W(3)) sif ();
   assign sif.pins = {irq_line_13_i, alt_mode_strap_i, power_ok_in_i};

   crc_sync #(
      .W(3)
   ) u_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .sif(sif)
   );

   logic pwr_ok_s;
   logic strap_s;
   logic irq_line_13_s;
   assign pwr_ok_s = sif.level[0];
   assign strap_s = sif.level[1];
   assign irq_line_13_s = sif.level[2];

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      crc_state_t st;
      logic [31:0] cnt;
      logic strap_done;
      logic [2:0] strap_cnt;
      logic alt_mode;
      logic pwr_prev;
      logic [7:0] port_ctrl;
      logic [7:0] sys_ctrl;
      logic [7:0] rdata;
      logic int_out;
      logic soft_rst;
      logic hard_rst;
      logic ignore_fpu_error_out;
      logic irq_line_13;
      logic coprocessor_error_in;
      logic pend_hard;
   } crc_st_t;

   crc_st_t state_q;
   crc_st_t state_d;

   localparam logic [31:0] SOFT_N = 32'(`CRC_SOFT_RST_CLKS);
   localparam logic [31:0] HARD_N = 32'(HARD_RST_CLKS);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic wr_port;
   logic wr_sys;
   logic hot_set;
   logic kbd_set;
   logic pwr_edge;
   logic trig;

   always_comb
   begin
      state_d = state_q;
      wr_port = wr_i && (addr_i == `CRC_OFF_PORT_CTRL);
      wr_sys = wr_i && (addr_i == `CRC_OFF_SYS_CTRL);
      hot_set = wr_port && wdata_i[`CRC_BIT_HOT_RESET]
         && !state_q.port_ctrl[`CRC_BIT_HOT_RESET];
      kbd_set = wr_sys && wdata_i[`CRC_BIT_KBD_RESET]
         && !state_q.sys_ctrl[`CRC_BIT_KBD_RESET];
      pwr_edge = pwr_ok_s && !state_q.pwr_prev;
      trig = hot_set || kbd_set || cpu_shutdown_i;
      state_d.pwr_prev = pwr_ok_s;

      // Latch the strap only once the synchroniser shows the pin, not its reset value
      if (!state_q.strap_done)
      begin
         if (state_q.strap_cnt == 3'(`CRC_STRAP_SETTLE_CLKS))
         begin
            state_d.alt_mode = strap_s;
            state_d.strap_done = 1'b1;
         end
         else
         begin
            state_d.strap_cnt = state_q.strap_cnt + 3'd1;
         end
      end

      if (wr_port)
      begin
         state_d.port_ctrl = wdata_i;
      end
      if (wr_sys)
      begin
         state_d.sys_ctrl = wdata_i;
      end

      unique case (state_q.st)
         CRC_IDLE:
         begin
            if (state_q.strap_done && (trig || state_q.pend_hard || pwr_edge))
            begin
               state_d.pend_hard = 1'b0;
               if (state_q.alt_mode)
               begin
                  state_d.st = CRC_HARD;
                  state_d.cnt = HARD_N - 32'd1;
               end
               else if (trig)
               begin
                  state_d.st = CRC_SOFT;
                  state_d.cnt = SOFT_N - 32'd1;
               end
            end
         end
         CRC_SOFT, CRC_HARD:
         begin
            if (state_q.cnt == 32'd0)
            begin
               state_d.st = CRC_IDLE;
            end
            else
            begin
               state_d.cnt = state_q.cnt - 32'd1;
            end
         end
         default:
         begin
            state_d.st = CRC_IDLE;
         end
      endcase

      // A power-good edge that cannot be served now is queued; the set beats the clear
      if (pwr_edge && !(state_q.strap_done && (state_q.st == CRC_IDLE)))
      begin
         state_d.pend_hard = 1'b1;
      end

      state_d.soft_rst = (state_d.st == CRC_SOFT);
      state_d.hard_rst = (state_d.st == CRC_HARD) || !pwr_ok_s && state_q.alt_mode;
      state_d.ignore_fpu_error_out = !state_q.alt_mode && state_q.strap_done && pic_ack_i;
      state_d.int_out = pic_int_req_i;
      state_d.coprocessor_error_in = state_q.sys_ctrl[`CRC_BIT_COPROCESSOR_ERROR_IN_EN] && !irq_line_13_s;
      state_d.irq_line_13 = !state_q.sys_ctrl[`CRC_BIT_COPROCESSOR_ERROR_IN_EN] && irq_line_13_s;

      state_d.rdata = 8'h00;
      if (rd_i)
      begin
         if (addr_i == `CRC_OFF_PORT_CTRL)
         begin
            state_d.rdata = state_q.port_ctrl;
         end
         else if (addr_i == `CRC_OFF_SYS_CTRL)
         begin
            state_d.rdata = state_q.sys_ctrl;
         end
         else if (addr_i == `CRC_OFF_STATUS)
         begin
            state_d.rdata[`CRC_ST_ALT_MODE] = state_q.alt_mode;
            state_d.rdata[`CRC_ST_SOFT_RST] = state_q.soft_rst;
            state_d.rdata[`CRC_ST_HARD_RST] = state_q.hard_rst;
            state_d.rdata[`CRC_ST_IRQ_LINE_13] = irq_line_13_s;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= '0;
         state_q.port_ctrl <= `CRC_RST_PORT_CTRL;
         state_q.sys_ctrl <= `CRC_RST_SYS_CTRL;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata_o = state_q.rdata;
   assign cpu_int_o = state_q.int_out;
   assign soft_reset_o = state_q.soft_rst;
   assign host_hard_reset_out_o = state_q.hard_rst;
   assign ignore_fpu_error_out_o = state_q.ignore_fpu_error_out;
   assign irq_line_13_req_o = state_q.irq_line_13;
   assign fpu_error_o = state_q.coprocessor_error_in;
endmodule // crc_top

// ===== tb/crc_host_model.sv
/* Host side model: measures soft and hard reset pulses.
 Assumes one clock shared with the device. */
`timescale 1ns/1ps
module crc_host_model (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // From device
   input wire logic soft_reset_i,
   input wire logic hard_reset_i,
   // Measured
   output logic [7:0] width_o,
   output logic [7:0] pulses_o,
   output logic [7:0] hwidth_o,
   output logic [7:0] hpulses_o
);
   logic [7:0] run_q;
   logic [7:0] hrun_q;
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         hrun_q <= 8'h00;
         hwidth_o <= 8'h00;
         hpulses_o <= 8'h00;
      end
      else if (hard_reset_i)
         hrun_q <= hrun_q + 8'h01;
      else if (hrun_q != 8'h00)
      begin
         hwidth_o <= hrun_q;
         hpulses_o <= hpulses_o + 8'h01;
         hrun_q <= 8'h00;
      end
   end
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         run_q <= 8'h00;
         width_o <= 8'h00;
         pulses_o <= 8'h00;
      end
      else if (soft_reset_i)
         run_q <= run_q + 8'h01;
      else if (run_q != 8'h00)
      begin
         width_o <= run_q;
         pulses_o <= pulses_o + 8'h01;
         run_q <= 8'h00;
      end
   end
endmodule // crc_host_model

// ===== tb/crc_top_properties.sv
/* Checker on the ports of crc_top.
 Assumes either strap setting; triggers are judged once the strap has settled. */
`timescale 1ns/1ps
module crc_chk #(
   parameter int HARD_RST_CLKS = 20
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Watched ports
   input wire logic [7:0] addr_i,
   input wire crc_pkg::crc_byte_t wdata_i,
   input wire logic wr_i,
   input wire logic cpu_shutdown_i,
   input wire logic pic_int_req_i,
   input wire logic cpu_int_o,
   input wire logic soft_reset_o,
   input wire logic host_hard_reset_out_o,
   input wire logic irq_line_13_req_o,
   input wire logic fpu_error_o
);
   import crc_pkg::*;
   logic hot_q, kbd_q, fen_q;
   logic [2:0] up_q;
   logic [31:0] hrun_q;
   wire busy = soft_reset_o | host_hard_reset_out_o;
   // Cycles since reset, and length of the current hard reset run
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         up_q <= 3'h0;
         hrun_q <= 32'h0;
      end
      else
      begin
         if (up_q != 3'h7)
            up_q <= up_q + 3'h1;
         if (host_hard_reset_out_o)
            hrun_q <= hrun_q + 32'h1;
         else
            hrun_q <= 32'h0;
      end
   end
   // Shadow of the trigger and pin select bits
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         hot_q <= 1'b0;
         kbd_q <= 1'b0;
         fen_q <= 1'b0;
      end
      else if (wr_i && addr_i == 8'h92)
         hot_q <= wdata_i[0];
      else if (wr_i && addr_i == 8'h4e)
      begin
         kbd_q <= wdata_i[1];
         fen_q <= wdata_i[4];
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   AST_SOFT_LEN: assert property ($rose(soft_reset_o) |-> soft_reset_o[*4] ##1 !soft_reset_o)
      else $error("soft reset width wrong");
   AST_SHUT: assert property (cpu_shutdown_i && !busy && up_q == 3'h7 |=> busy)
      else $error("shutdown did not reset");
   AST_HOT: assert property (wr_i && addr_i == 8'h92 && wdata_i[0] && !hot_q && !busy
      && up_q == 3'h7 |=> busy)
      else $error("hot reset bit did not reset");
   AST_KBD: assert property (wr_i && addr_i == 8'h4e && wdata_i[1] && !kbd_q && !busy
      && up_q == 3'h7 |=> busy)
      else $error("keyboard reset bit did not reset");
   AST_HARD_LEN: assert property ($fell(host_hard_reset_out_o) |-> hrun_q >= 32'(HARD_RST_CLKS))
      else $error("hard reset pulse too short");
   AST_INT: assert property (cpu_int_o == $past(pic_int_req_i))
      else $error("interrupt output wrong");
   AST_EXCL: assert property (!(soft_reset_o && host_hard_reset_out_o))
      else $error("both reset outputs active");
   AST_IRQ_SEL: assert property (fen_q && $past(fen_q) |-> !irq_line_13_req_o)
      else $error("irq_line_13 active with error input selected");
   AST_COPROCESSOR_ERROR_IN_OFF: assert property (!fen_q && !$past(fen_q) |-> !fpu_error_o)
      else $error("error input active while irq_line_13 selected");
   COV_SOFT: cover property ($rose(soft_reset_o));
   COV_COPROCESSOR_ERROR_IN: cover property (fen_q && fpu_error_o);
   COV_INT: cover property ($rose(cpu_int_o));
   COV_HARD: cover property ($rose(host_hard_reset_out_o));
endmodule // crc_chk
bind crc_top crc_chk #(.HARD_RST_CLKS(HARD_RST_CLKS)) u_chk (.clock_i, .reset_i, .addr_i,
   .wdata_i, .wr_i, .cpu_shutdown_i, .pic_int_req_i, .cpu_int_o, .soft_reset_o,
   .host_hard_reset_out_o, .irq_line_13_req_o, .fpu_error_o);

// ===== tb/crc_top_tb.sv
/* Self-checking bench for crc_top.
 Assumes x86 strap first, then a mid-run reset into the alternate processor mode. */
`timescale 1ns/1ps
module crc_top_tb;
   import crc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b0;
   logic shut = 1'b0, preq = 1'b0, pack = 1'b0, pwr = 1'b1, strap = 1'b0;
   logic [7:0] hwidth, hpulses;
   logic [7:0] addr = 8'h00, width, pulses, exp_p = 8'h00;
   crc_byte_t wdata = 8'h00, rdata;
   logic cint, srst, hrst, ign, i13, fe;
   int error_cnt = 0, cmp_count = 0;
   always #5 clk = ~clk;
   crc_top #(.HARD_RST_CLKS(20)) uut (.clock_i(clk), .reset_i(rst), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .power_ok_in_i(pwr),
      .alt_mode_strap_i(strap), .irq_line_13_i(pin), .cpu_shutdown_i(shut),
      .pic_int_req_i(preq), .pic_ack_i(pack), .cpu_int_o(cint), .soft_reset_o(srst),
      .host_hard_reset_out_o(hrst), .ignore_fpu_error_out_o(ign), .irq_line_13_req_o(i13),
      .fpu_error_o(fe));
   crc_host_model host (.clock_i(clk), .reset_i(rst), .soft_reset_i(srst),
      .hard_reset_i(hrst), .width_o(width), .pulses_o(pulses), .hwidth_o(hwidth),
      .hpulses_o(hpulses));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   task automatic pulse_seen();
      exp_p++;
      repeat (8) @(posedge clk);
      #1 chk("pulses", exp_p, pulses);
      chk("width", 8'h04, width);
      chk1("hard", 1'b0, hrst);
   endtask
   task automatic t_hot();
      wr_reg(8'h92, 8'h01);
      pulse_seen();
      wr_reg(8'h92, 8'h00);
      wr_reg(8'h92, 8'h01);
      wr_reg(8'h92, 8'h00);
      wr_reg(8'h92, 8'h01);
      pulse_seen();
      rd_reg(8'h92, 8'h01);
   endtask
   task automatic t_other();
      wr_reg(8'h4e, 8'h02);
      pulse_seen();
      wr_reg(8'h4e, 8'h00);
      @(posedge clk);
      shut <= 1'b1;
      @(posedge clk);
      shut <= 1'b0;
      pulse_seen();
   endtask
   task automatic t_int();
      @(posedge clk);
      preq <= 1'b1;
      pack <= 1'b1;
      @(posedge clk);
      preq <= 1'b0;
      pack <= 1'b0;
      #1 chk1("cpu_int", 1'b1, cint);
      chk1("ignore", 1'b1, ign);
      @(posedge clk);
      #1 chk1("cpu_int", 1'b0, cint);
      chk1("ignore", 1'b0, ign);
   endtask
   task automatic t_irq();
      @(posedge clk);
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk1("irq_line_13", 1'b1, i13);
      chk1("fpu_err", 1'b0, fe);
      wr_reg(8'h4e, 8'h10);
      pin <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk1("fpu_err", 1'b1, fe);
      chk1("irq_line_13", 1'b0, i13);
      rd_reg(8'h4e, 8'h10);
   endtask
   task automatic t_alt();
      @(posedge clk);
      strap <= 1'b1;
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (30) @(posedge clk);
      #1 chk("hard_pulses", 8'h01, hpulses);
      chk("hard_width", 8'h14, hwidth);
      chk("soft_pulses", 8'h00, pulses);
      rd_reg(8'h00, 8'h01);
      wr_reg(8'h92, 8'h01);
      repeat (24) @(posedge clk);
      #1 chk("hard_pulses", 8'h02, hpulses);
      chk("hard_width", 8'h14, hwidth);
      @(posedge clk);
      shut <= 1'b1;
      pack <= 1'b1;
      @(posedge clk);
      shut <= 1'b0;
      pack <= 1'b0;
      #1 chk1("ignore", 1'b0, ign);
      repeat (24) @(posedge clk);
      #1 chk("hard_pulses", 8'h03, hpulses);
      chk("soft_pulses", 8'h00, pulses);
      @(posedge clk);
      pwr <= 1'b0;
      repeat (10) @(posedge clk);
      pwr <= 1'b1;
      #1 chk1("hard", 1'b1, hrst);
      repeat (26) @(posedge clk);
      #1 chk("hard_pulses", 8'h04, hpulses);
      chk("hard_width", 8'h1e, hwidth);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd_reg(8'h92, 8'h00);
      rd_reg(8'h4e, 8'h00);
      rd_reg(8'h55, 8'h00);
      rd_reg(8'h00, 8'h00);
      t_hot();
      t_other();
      t_int();
      t_irq();
      t_alt();
      print_verdict();
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
endmodule // crc_top_tb
